/* logic/chan4_io_pkg.sv */
/*
 * constants for the channel-4 capture/compare function select block:
 * register byte offsets, field positions, reset values and selector codes.
 * assumes a 32-bit ahb-lite register bus with word-aligned registers.
 */
`default_nettype none
package chan4_io_pkg;
   // ==========================================================
   // register map (byte addresses)
   // ==========================================================
   localparam logic [7:0] OFF_CTRL_HIGH = 8'h00;
   localparam logic [7:0] OFF_CTRL_LOW  = 8'h04;
   localparam logic [7:0] OFF_MODE      = 8'h08;
   localparam logic [7:0] OFF_CNT       = 8'h0C;
   localparam logic [7:0] OFF_GR_A      = 8'h10;
   localparam logic [7:0] OFF_GR_C      = 8'h14;
   localparam logic [7:0] OFF_GR_D      = 8'h18;
   localparam logic [7:0] OFF_PINS      = 8'h1C;
   localparam logic [7:0] OFF_CNT_CTRL  = 8'h20;

   // ==========================================================
   // field positions and reset values
   // ==========================================================
   localparam int SEL_LO_POS  = 0;
   localparam int SEL_HI_POS  = 4;
   localparam int SEL_W       = 4;
   localparam int BUF_C_POS   = 4;
   localparam int BUF_D_POS   = 5;
   localparam logic [3:0] SEL_RESET = 4'h0;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   // ==========================================================
   // selector decode
   // ==========================================================
   localparam int SEL_CAPTURE_BIT = 3;
   localparam int SEL_INIT_BIT    = 2;
   localparam logic [1:0] ACT_NONE   = 2'h0;
   localparam logic [1:0] ACT_LOW    = 2'h1;
   localparam logic [1:0] ACT_HIGH   = 2'h2;
   localparam logic [1:0] ACT_TOGGLE = 2'h3;
   localparam logic [1:0] EDGE_RISE  = 2'h0;
   localparam logic [1:0] EDGE_FALL  = 2'h1;
   localparam logic [1:0] EDGE_BOTH  = 2'h2;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HRESP_OKAY    = 2'h0;
endpackage
`default_nettype wire

/* logic/cc_unit.sv */
/*
 * one capture/compare unit: a general register with its selector, its pin
 * output and its capture edge detector.
 * assumes the pin input is synchronous to hclk and the counter is shared.
 */
`timescale 1ns/1ps
`default_nettype none
module cc_unit
   import chan4_io_pkg::*;
#(
   parameter int W = 16
) (
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic [3:0]   sel,
   input  wire logic         disabled,
   input  wire logic         sel_wr,
   input  wire logic [W-1:0] counter,
   input  wire logic         cnt_tick,
   input  wire logic         gr_wr,
   input  wire logic [W-1:0] gr_wdata,
   input  wire logic         pin_in,
   output logic [W-1:0]      gr,
   output logic              pin_out,
   output logic              pin_oe
);
   // ==========================================================
   // decode
   // ==========================================================
   wire       is_cap   = sel[SEL_CAPTURE_BIT];
   wire [1:0] low      = sel[1:0];
   wire       cmp_on   = !disabled && !is_cap && low != ACT_NONE;
   wire       match    = cnt_tick && counter == gr;
   logic      pin_prev;
   wire       rise     = pin_in && !pin_prev;
   wire       fall     = !pin_in && pin_prev;
   wire       cap_edge = !disabled && is_cap &&
                         ((low == EDGE_RISE && rise) ||
                          (low == EDGE_FALL && fall) ||
                          (low == EDGE_BOTH && (rise || fall)));
   logic      next_pin;
   // loaded one edge after the write: sel still holds the old code while sel_wr is high
   logic      init_load;

   always_comb begin
      next_pin = pin_out;
      if (init_load) begin
         next_pin = sel[SEL_INIT_BIT];
      end else if (cmp_on && match) begin
         case (low)
            ACT_LOW:    next_pin = 1'b0;
            ACT_HIGH:   next_pin = 1'b1;
            ACT_TOGGLE: next_pin = !pin_out;
            default:    next_pin = pin_out;
         endcase
      end
   end

   // ==========================================================
   // state
   // ==========================================================
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_prev <= 1'b0;
         init_load <= 1'b0;
         pin_out  <= 1'b0;
         pin_oe   <= 1'b0;
         gr       <= '1;
      end else begin
         pin_prev <= pin_in;
         init_load <= sel_wr;
         pin_out  <= next_pin;
         pin_oe   <= !disabled && !is_cap && low != ACT_NONE;
         if (cap_edge) begin
            gr <= counter;
         end else if (gr_wr) begin
            gr <= gr_wdata;
         end
      end
   end

   capture_copies_a: assert property (@(posedge hclk) disable iff (!hresetn)
      cap_edge |=> gr == $past(counter)) else $error("capture value wrong");
   toggle_match_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (cmp_on && match && low == ACT_TOGGLE && !init_load) |=> pin_out != $past(pin_out))
      else $error("toggle missed");
   high_match_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (cmp_on && match && low == ACT_HIGH && !init_load) |=> pin_out)
      else $error("drive high missed");
   undefined_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (is_cap && low == ACT_TOGGLE) |-> !cap_edge && !cmp_on)
      else $error("undefined code acted");
endmodule
`default_nettype wire

/* logic/chan4_io_control_select.sv */
/*
 * channel-4 capture/compare function select for general registers a, c, d,
 * with an ahb-lite register slave and a free-running channel counter.
 * assumes one slave on the bus (hreadyout is hready) and synchronous pins.
 */
// Chosen here: the register addresses and the AHB-Lite register port.
// Summary of operation
// - selector for register a in high control bits 3..0, resets to zero.
// - selector for register d in low control bits 7..4, resets to zero.
// - selector for register c in low control bits 3..0, resets to zero.
// - bit 3 clear is compare; bit 2 initial level; 00 off, 01 drive low.
// - compare code 10 drives the pin high on every match.
// - compare code 11 toggles the pin on every match.
// - capture code 00 latches the counter on a rising pin edge.
// - capture code 01 latches the counter on a falling pin edge.
// - capture code 10 latches the counter on both pin edges.
// - buffer mode for d disables its capture and compare.
// - buffer mode for c disables its capture and compare.
`timescale 1ns/1ps
`default_nettype none
module chan4_io_control_select
   import chan4_io_pkg::*;
#(
   parameter int W = 16
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic [1:0]       hresp,
   input  wire logic        timer_pin_a_in,
   input  wire logic        timer_pin_c_in,
   input  wire logic        timer_pin_d_in,
   output logic             timer_pin_a_out,
   output logic             timer_pin_a_oe,
   output logic             timer_pin_c_out,
   output logic             timer_pin_c_oe,
   output logic             timer_pin_d_out,
   output logic             timer_pin_d_oe
);
   // ==========================================================
   // bus address phase capture
   // ==========================================================
   logic       wr_pend;
   logic [7:0] wr_addr;
   logic [7:0] chan4_io_control_high;
   logic [7:0] chan4_io_control_low;
   logic [7:0] chan4_mode_register;
   logic       cnt_run;
   logic [W-1:0] counter;
   wire  [W-1:0] general_register_a;
   wire  [W-1:0] general_register_c;
   wire  [W-1:0] general_register_d;
   wire  pa_out, pa_oe, pc_out, pc_oe, pd_out, pd_oe;

   wire access   = hsel && hready && htrans == HTRANS_NONSEQ;
   wire rd_take  = access && !hwrite;
   wire wr_high  = wr_pend && wr_addr == OFF_CTRL_HIGH;
   wire wr_low   = wr_pend && wr_addr == OFF_CTRL_LOW;
   wire wr_mode  = wr_pend && wr_addr == OFF_MODE;
   wire wr_cnt   = wr_pend && wr_addr == OFF_CNT;
   wire wr_gra   = wr_pend && wr_addr == OFF_GR_A;
   wire wr_grc   = wr_pend && wr_addr == OFF_GR_C;
   wire wr_grd   = wr_pend && wr_addr == OFF_GR_D;
   wire wr_cctl  = wr_pend && wr_addr == OFF_CNT_CTRL;

   wire [3:0] func_select_a = chan4_io_control_high[SEL_LO_POS +: SEL_W];
   wire [3:0] func_select_d = chan4_io_control_low[SEL_HI_POS +: SEL_W];
   wire [3:0] func_select_c = chan4_io_control_low[SEL_LO_POS +: SEL_W];
   wire buffer_mode_c = chan4_mode_register[BUF_C_POS];
   wire buffer_mode_d = chan4_mode_register[BUF_D_POS];

   // ==========================================================
   // read mux
   // ==========================================================
   logic [31:0] rd_mux;
   always_comb begin
      case (haddr[7:0])
         OFF_CTRL_HIGH: rd_mux = {24'h00_0000, chan4_io_control_high};
         OFF_CTRL_LOW:  rd_mux = {24'h00_0000, chan4_io_control_low};
         OFF_MODE:      rd_mux = {24'h00_0000, chan4_mode_register};
         OFF_CNT:       rd_mux = 32'(counter);
         OFF_GR_A:      rd_mux = 32'(general_register_a);
         OFF_GR_C:      rd_mux = 32'(general_register_c);
         OFF_GR_D:      rd_mux = 32'(general_register_d);
         OFF_PINS:      rd_mux = {26'h000_0000, pd_oe, pc_oe, pa_oe, pd_out, pc_out, pa_out};
         OFF_CNT_CTRL:  rd_mux = {31'h0000_0000, cnt_run};
         default:       rd_mux = 32'h0000_0000;
      endcase
   end

   // ==========================================================
   // bus and control registers
   // ==========================================================
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend   <= 1'b0;
         wr_addr   <= 8'h00;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= HRESP_OKAY;
      end else begin
         wr_pend <= access && hwrite;
         wr_addr <= haddr[7:0];
         if (rd_take) begin
            hrdata <= rd_mux;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chan4_io_control_high <= BYTE_RESET;
         chan4_io_control_low  <= BYTE_RESET;
         chan4_mode_register   <= BYTE_RESET;
         cnt_run               <= 1'b0;
      end else begin
         if (wr_high) chan4_io_control_high <= hwdata[7:0];
         if (wr_low)  chan4_io_control_low  <= hwdata[7:0];
         if (wr_mode) chan4_mode_register   <= hwdata[7:0];
         if (wr_cctl) cnt_run               <= hwdata[0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         counter <= '0;
      end else if (wr_cnt) begin
         counter <= hwdata[W-1:0];
      end else if (cnt_run) begin
         counter <= counter + 1'b1;
      end
   end

   // ==========================================================
   // capture/compare units
   // ==========================================================
   cc_unit #(.W(W)) unit_a (
      .hclk(hclk), .hresetn(hresetn), .sel(func_select_a), .disabled(1'b0),
      .sel_wr(wr_high), .counter(counter), .cnt_tick(cnt_run), .gr_wr(wr_gra),
      .gr_wdata(hwdata[W-1:0]), .pin_in(timer_pin_a_in), .gr(general_register_a),
      .pin_out(pa_out), .pin_oe(pa_oe));
   // buffer mode gates capture and compare, not only the pin enable
   cc_unit #(.W(W)) unit_c (
      .hclk(hclk), .hresetn(hresetn), .sel(func_select_c), .disabled(buffer_mode_c),
      .sel_wr(wr_low), .counter(counter), .cnt_tick(cnt_run), .gr_wr(wr_grc),
      .gr_wdata(hwdata[W-1:0]), .pin_in(timer_pin_c_in), .gr(general_register_c),
      .pin_out(pc_out), .pin_oe(pc_oe));
   cc_unit #(.W(W)) unit_d (
      .hclk(hclk), .hresetn(hresetn), .sel(func_select_d), .disabled(buffer_mode_d),
      .sel_wr(wr_low), .counter(counter), .cnt_tick(cnt_run), .gr_wr(wr_grd),
      .gr_wdata(hwdata[W-1:0]), .pin_in(timer_pin_d_in), .gr(general_register_d),
      .pin_out(pd_out), .pin_oe(pd_oe));

   // ==========================================================
   // pin outputs
   // ==========================================================
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer_pin_a_out <= 1'b0;
         timer_pin_a_oe  <= 1'b0;
         timer_pin_c_out <= 1'b0;
         timer_pin_c_oe  <= 1'b0;
         timer_pin_d_out <= 1'b0;
         timer_pin_d_oe  <= 1'b0;
      end else begin
         timer_pin_a_out <= pa_out;
         timer_pin_a_oe  <= pa_oe;
         timer_pin_c_out <= pc_out;
         timer_pin_c_oe  <= pc_oe;
         timer_pin_d_out <= pd_out;
         timer_pin_d_oe  <= pd_oe;
      end
   end

   reset_disabled_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (func_select_a == SEL_RESET) |=> ##1 !timer_pin_a_oe) else $error("pin a driven while off");
   buffer_c_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
      buffer_mode_c [*3] |-> !timer_pin_c_oe) else $error("c active in buffer mode");
   buffer_d_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
      buffer_mode_d [*3] |-> !timer_pin_d_oe) else $error("d active in buffer mode");
   init_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_low |=> ##2 timer_pin_c_out == $past(chan4_io_control_low[SEL_INIT_BIT], 2))
      else $error("initial level wrong");
endmodule
`default_nettype wire

/* test/pin_partner.sv */
/*
 * far-side source of one timer pin: an outside driver holding a level.
 * assumes the testbench moves the level right after a rising hclk edge.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
   input  wire logic pin_out,
   input  wire logic pin_oe,
   input  wire logic lvl,
   output logic      pin_in
);
   // ==========================================================
   // wire level
   // ==========================================================
   // the block wins while it drives; the outside source backs off then
   assign pin_in = pin_oe ? pin_out : lvl;
endmodule
`default_nettype wire

/* test/tb_chan4_io_control_select.sv */
/*
 * self-checking bench: ahb-lite register access, compare and capture codes.
 * assumes one slave (hready is hreadyout) and zero-wait transfers.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_chan4_io_control_select
   import chan4_io_pkg::*;
;
   logic             hclk, hresetn, hsel, hwrite, lvl_a, lvl_c, lvl_d, oe, lv;
   logic [1:0]       htrans;
   logic [3:0]       code;
   logic [31:0]      haddr, hwdata, rd;
   wire logic [31:0] hrdata;
   wire logic [1:0]  hresp;
   wire logic        hreadyout, in_a, in_c, in_d, out_a, out_c, out_d, oe_a, oe_c, oe_d;
   int               err_total, checked;

   chan4_io_control_select #(.W(16)) i_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .timer_pin_a_in(in_a), .timer_pin_c_in(in_c),
      .timer_pin_d_in(in_d), .timer_pin_a_out(out_a), .timer_pin_a_oe(oe_a),
      .timer_pin_c_out(out_c), .timer_pin_c_oe(oe_c), .timer_pin_d_out(out_d), .timer_pin_d_oe(oe_d));
   pin_partner p_a (.pin_out(out_a), .pin_oe(oe_a), .lvl(lvl_a), .pin_in(in_a));
   pin_partner p_c (.pin_out(out_c), .pin_oe(oe_c), .lvl(lvl_c), .pin_in(in_c));
   pin_partner p_d (.pin_out(out_d), .pin_oe(oe_d), .lvl(lvl_d), .pin_in(in_d));

   // ==========================================================
   // bus tasks and checks
   // ==========================================================
   task automatic close_out;
      if (err_total == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
         err_total++;
      end
   endtask

   // bounded: a slave that never answers ends the run
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_total++;
         close_out();
      end
   endtask

   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
      hsel   <= 1'b1;
      haddr  <= {24'h0000_00, a};
      hwrite <= w;
      htrans <= HTRANS_NONSEQ;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
      chk("hresp", {30'h0, hresp}, {30'h0, HRESP_OKAY});
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask

   // capture on unit c (u=0) or d (u=1); counter stopped so the value is known
   task automatic cap(input int u, input logic [3:0] c, input logic bm);
      logic [7:0]  ga;
      logic [31:0] cv;
      logic        r, f;
      ga = u ? OFF_GR_D : OFF_GR_C;
      cv = {20'h0_0000, c, 8'h5A};
      r  = !bm && (c[1:0] == 2'h0 || c[1:0] == 2'h2);
      f  = !bm && (c[1:0] == 2'h1 || c[1:0] == 2'h2);
      wr(OFF_MODE, bm ? (u ? 32'h0000_0020 : 32'h0000_0010) : 32'h0000_0000);
      wr(OFF_CNT, cv);
      wr(ga, 32'h0000_1234);
      wr(OFF_CTRL_LOW, u ? {24'h0000_00, c, 4'h0} : {28'h0000_000, c});
      if (u) lvl_d <= 1'b1;
      else lvl_c <= 1'b1;
      repeat (4) @(posedge hclk);
      xfer(ga, 1'b0, 32'h0000_0000);
      chk("capture rise", rd, r ? cv : 32'h0000_1234);
      wr(ga, 32'h0000_1234);
      if (u) lvl_d <= 1'b0;
      else lvl_c <= 1'b0;
      repeat (4) @(posedge hclk);
      xfer(ga, 1'b0, 32'h0000_0000);
      chk("capture fall", rd, f ? cv : 32'h0000_1234);
   endtask

   // ==========================================================
   // sequence
   // ==========================================================
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   initial begin
      {hresetn, hsel, hwrite, lvl_a, lvl_c, lvl_d} = 6'h00;
      {htrans, haddr, hwdata, err_total, checked} = '0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      xfer(OFF_CTRL_HIGH, 1'b0, 32'h0000_0000);
      chk("ctrl high reset", rd, 32'h0000_0000);
      xfer(OFF_CTRL_LOW, 1'b0, 32'h0000_0000);
      chk("ctrl low reset", rd, 32'h0000_0000);
      xfer(8'h40, 1'b0, 32'h0000_0000);
      chk("unmapped", rd, 32'h0000_0000);
      wr(OFF_GR_A, 32'h0000_0005);
      // every compare code on a, each from counter zero to one match at 5
      for (int i = 0; i < 8; i++) begin
         code = i[3:0];
         oe   = code[1:0] != 2'h0;
         wr(OFF_CNT_CTRL, 32'h0000_0000);
         wr(OFF_CNT, 32'h0000_0000);
         wr(OFF_CTRL_HIGH, {28'h0000_000, code});
         repeat (3) @(posedge hclk);
         xfer(OFF_PINS, 1'b0, 32'h0000_0000);
         chk("pin a initial", rd & {28'h0, 3'h4, oe}, {28'h0, oe, 2'h0, oe & code[2]});
         wr(OFF_CNT_CTRL, 32'h0000_0001);
         repeat (12) @(posedge hclk);
         wr(OFF_CNT_CTRL, 32'h0000_0000);
         lv = (code[1:0] == 2'h3) ? ~code[2] : code[1];
         chk("pin a port", {30'h0, oe_a, out_a & oe_a}, {30'h0, oe, oe & lv});
      end
      for (int u = 0; u < 2; u++) begin
         for (int c = 8; c < 16; c++) begin
            cap(u, c[3:0], 1'b0);
         end
         cap(u, 4'hA, 1'b1);
      end
      wr(OFF_CTRL_LOW, 32'h0000_0033);
      for (int m = 0; m < 2; m++) begin
         wr(OFF_MODE, m ? 32'h0000_0020 : 32'h0000_0010);
         repeat (3) @(posedge hclk);
         xfer(OFF_PINS, 1'b0, 32'h0000_0000);
         chk("buffer oe", rd & 32'h0000_0030, m ? 32'h0000_0010 : 32'h0000_0020);
         chk("buffer port", {30'h0, oe_d, oe_c}, m ? 32'h0000_0001 : 32'h0000_0002);
      end
      wr(OFF_CTRL_LOW, 32'h0000_00C5);
      xfer(OFF_CTRL_LOW, 1'b0, 32'h0000_0000);
      chk("ctrl low fields", rd, 32'h0000_00C5);
      close_out();
   end
endmodule
`default_nettype wire
